/* File: shared/loop_test_defs.svh */
// Register offsets, field positions, reset values and timing counts for the loop test block
`ifndef LOOP_TEST_DEFS_SVH
`define LOOP_TEST_DEFS_SVH

// Clock and time base
`define CLK_FREQ_HZ 40000000
`define SEC_TIME_MS 1000
`define SEC_CYCLES ((`CLK_FREQ_HZ / 1000) * `SEC_TIME_MS)
`define REMOTE_CMD_S 10
`define TIMEOUT_MIN 10
`define TIMEOUT_RST (16'(`TIMEOUT_MIN * 60))

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_CFG 8'h04
`define REG_TIMEOUT 8'h08
`define REG_STATUS 8'h0C
`define REG_ERRCNT 8'h10
`define REG_DSX1_MASK 8'h14
`define REG_DSL_MASK 8'h18
`define REG_ELAPSED0 8'h20
`define REG_ELAPSED4 8'h30

// Field positions and widths
`define CMD_W 12
`define CFG_W 7
`define DSX1_MASK_W 24
`define STATUS_REFUSED_BIT 7

// Reset values
`define CFG_RST 7'h03
`define DSX1_MASK_RST 24'h000000
`define DSL_MASK_RST 32'h00000000
`define PRBS_SEED 9'h1FF
`define PRBS_SYNC_BITS 4'h9

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: shared/loop_test_pkg.sv */
// Types shared by the loop test control block
package loop_test_pkg;

   // Cross-connect mode of a port
   typedef enum logic [1:0] {
      MODE_BYPASS = 2'h0,
      MODE_DS1 = 2'h1,
      MODE_DS0 = 2'h2
   } port_mode_t;

   // Index of each test in the activity and elapsed vectors
   typedef enum logic [2:0] {
      T_NET = 3'h0,
      T_REP = 3'h1,
      T_DTE = 3'h2,
      T_REM = 3'h3,
      T_PRBS = 3'h4
   } test_idx_t;

   // Command pulses written to the control register, bit 0 last
   typedef struct packed {
      logic error_count_clear;
      logic abort_all;
      logic prbs_stop;
      logic prbs_start;
      logic remote_up_sel;
      logic remote_send;
      logic dte_stop;
      logic dte_start;
      logic rep_stop;
      logic rep_start;
      logic line_stop;
      logic line_start;
   } cmd_t;

   // Static configuration, bit 0 last
   typedef struct packed {
      logic cross_connect;
      port_mode_t dsx1_mode;
      port_mode_t dsl_mode;
      logic timeout_en;
      logic dsx1_variant;
   } cfg_t;

endpackage : loop_test_pkg

/* File: hdl/loop_test_ctrl.sv */
// Loopback, remote loop command and 511 pattern test control with AXI4-Lite registers
`timescale 1ns/1ps
`include "loop_test_defs.svh"

module loop_test_ctrl import loop_test_pkg::*; #(
   parameter int unsigned SEC_CYCLES = `SEC_CYCLES
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Line side bit streams
   input wire logic net_rx_bit,
   input wire logic net_strobe,
   input wire logic [4:0] net_slot,
   input wire logic dte_rx_bit,
   input wire logic [4:0] dte_slot,
   output logic net_tx_bit,
   output logic dte_tx_bit,
   // Core (framer and cross-connect) side bit streams
   input wire logic core_net_tx_bit,
   input wire logic core_dte_tx_bit,
   output logic core_net_rx_bit,
   output logic core_dte_rx_bit,
   // Loop code detector and remote command sender
   input wire logic remote_up_det,
   input wire logic remote_down_det,
   output logic remote_cmd_active,
   output logic remote_cmd_up,
   // Indicators and management channel
   output logic test_led,
   output logic dte_ais,
   output logic eoc_enable
);

   // Bus holding registers
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;

   // Software state
   cfg_t cfg_reg;
   logic [15:0] timeout_reg;
   logic [`DSX1_MASK_W-1:0] dsx1_mask_reg;
   logic [31:0] dsl_mask_reg;
   logic refused_reg;
   logic [31:0] errcnt_reg;

   // Test state
   logic net_user_reg, net_remote_reg, rep_reg, dte_reg, rem_reg, rem_up_reg, prbs_reg;
   logic [25:0] sec_cnt_reg;

   // Pattern generator and checker
   logic [8:0] gen_reg;
   logic [8:0] chk_reg;
   logic [3:0] sync_reg;

   // Registered line outputs
   logic net_tx_reg, dte_tx_reg, core_net_rx_reg, core_dte_rx_reg;
   logic led_reg, ais_reg, eoc_reg;

   // Write channel joining: address and data may arrive in either order
   wire aw_take = awvalid & awready_reg;
   wire w_take = wvalid & wready_reg;
   wire aw_have = aw_held_reg | aw_take;
   wire w_have = w_held_reg | w_take;
   wire do_write = aw_have & w_have & ~bvalid_reg;
   wire [7:0] wa = aw_held_reg ? waddr_reg : awaddr;
   wire [31:0] wd = w_held_reg ? wdata_reg : wdata;
   wire [3:0] ws = w_held_reg ? wstrb_reg : wstrb;
   wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
   wire [31:0] wd_m = wd & wmask;
   wire aw_held_next = aw_have & ~do_write;
   wire w_held_next = w_have & ~do_write;
   wire bvalid_next = do_write | (bvalid_reg & ~bready);

   // Write address decoding
   wire wr_ctrl = do_write & (wa == `REG_CTRL);
   wire wr_cfg = do_write & (wa == `REG_CFG);
   wire wr_to = do_write & (wa == `REG_TIMEOUT);
   wire wr_stat = do_write & (wa == `REG_STATUS);
   wire wr_dsx1 = do_write & (wa == `REG_DSX1_MASK);
   wire wr_dsl = do_write & (wa == `REG_DSL_MASK);
   // Read-only registers accept writes silently; only holes and misaligned addresses answer with an error
   wire wa_mapped = (wa <= `REG_DSL_MASK) ||
                    ((wa >= `REG_ELAPSED0) && (wa <= `REG_ELAPSED4));
   wire wa_ok = wa_mapped & (wa[1:0] == 2'h0);

   // Command pulses exist only in the cycle of the control write
   cmd_t cmd;
   assign cmd = wr_ctrl ? cmd_t'(wd_m[`CMD_W-1:0]) : cmd_t'('0);

   // Activity view, one bit per test
   wire net_act = net_user_reg | net_remote_reg;
   wire [4:0] act = {prbs_reg, rem_reg, dte_reg, rep_reg, net_act};

   // Elapsed time, per test
   wire sec_tick = (sec_cnt_reg == 26'(SEC_CYCLES - 1));
   logic [4:0][15:0] tot_sec;
   logic [4:0][23:0] hms;
   logic [4:0] start_p;
   logic [4:0] timed_out;

   // Start permission for each test
   wire net_ok = cmd.line_start & ~net_act & ~rep_reg & ~dte_reg & ~rem_reg & ~prbs_reg;
   wire rep_ok = cmd.rep_start & ~rep_reg & ~net_act & ~dte_reg & ~rem_reg;
   wire dte_ok = cmd.dte_start & ~dte_reg & ~net_act & ~rep_reg & ~rem_reg;
   wire rem_ok = cmd.remote_send & ~rem_reg & ~net_act & ~rep_reg & ~dte_reg & ~prbs_reg &
                 ~cfg_reg.cross_connect;
   wire prbs_ok = cmd.prbs_start & ~prbs_reg;
   wire refuse = (cmd.line_start & ~net_ok) | (cmd.rep_start & ~rep_ok) |
                 (cmd.dte_start & ~dte_ok) | (cmd.remote_send & ~rem_ok) |
                 (cmd.prbs_start & ~prbs_ok);

   // A detected up code loops the line unless a DTE-side loop or pattern holds it
   wire up_take = remote_up_det & ~rep_reg & ~dte_reg & ~prbs_reg;
   wire rem_expire = rem_reg & (tot_sec[T_REM] >= 16'(`REMOTE_CMD_S));

   // Next test state; a start beats a stop in the same cycle
   wire net_user_next = (net_user_reg & ~(cmd.line_stop | cmd.abort_all | timed_out[T_NET])) |
                        net_ok;
   wire net_remote_next = (net_remote_reg & ~(remote_down_det | timed_out[T_NET])) |
                          up_take;
   wire rep_next = (rep_reg & ~(cmd.rep_stop | cmd.abort_all | timed_out[T_REP])) | rep_ok;
   wire dte_next = (dte_reg & ~(cmd.dte_stop | cmd.abort_all | timed_out[T_DTE])) | dte_ok;
   // Neither stop nor abort touches the remote command, only its expiry
   wire rem_next = (rem_reg & ~rem_expire) | rem_ok;
   // Abort all is deliberately absent from the pattern test's clear terms
   wire prbs_next = (prbs_reg & ~(cmd.prbs_stop | timed_out[T_PRBS])) | prbs_ok;

   assign start_p = {prbs_ok, rem_ok, dte_ok, rep_ok, (net_ok | up_take) & ~net_act};

   // Elapsed counters: cleared on start, held after stop so the result stays readable
   for (genvar i = 0; i < 5; i++) begin : g_elapsed
      logic [15:0] tot_reg;
      logic [5:0] s_reg, m_reg;
      logic [7:0] h_reg;
      wire s_wrap = (s_reg == 6'h3B);
      wire m_wrap = (m_reg == 6'h3B);
      // Hours saturate so a forgotten test never wraps back to a short time
      always_ff @(posedge aclk) begin
         if (!aresetn || start_p[i]) begin
            tot_reg <= 16'h0000;
            s_reg <= 6'h00;
            m_reg <= 6'h00;
            h_reg <= 8'h00;
         end else if (act[i] && sec_tick) begin
            tot_reg <= (tot_reg == 16'hFFFF) ? tot_reg : tot_reg + 16'h0001;
            s_reg <= s_wrap ? 6'h00 : s_reg + 6'h01;
            if (s_wrap) begin
               m_reg <= m_wrap ? 6'h00 : m_reg + 6'h01;
               if (m_wrap && h_reg != 8'hFF) begin
                  h_reg <= h_reg + 8'h01;
               end
            end
         end
      end
      assign tot_sec[i] = tot_reg;
      assign hms[i] = {h_reg, 2'h0, m_reg, 2'h0, s_reg};
      // The remote command has its own fixed length instead of the user timeout
      assign timed_out[i] = (i != T_REM) && act[i] && cfg_reg.timeout_en &&
                            (tot_reg >= timeout_reg);
   end

   // One-second time base
   always_ff @(posedge aclk) begin
      if (!aresetn || sec_tick) begin
         sec_cnt_reg <= 26'h0000000;
      end else begin
         sec_cnt_reg <= sec_cnt_reg + 26'h0000001;
      end
   end

   // Bus handshake flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `RESP_OKAY;
      end else begin
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         awready_reg <= ~aw_held_next & ~bvalid_next;
         wready_reg <= ~w_held_next & ~bvalid_next;
         bvalid_reg <= bvalid_next;
         if (do_write) begin
            bresp_reg <= wa_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

   // Capture of address and data that arrive ahead of their partner
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         waddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
      end else begin
         if (aw_take) begin
            waddr_reg <= awaddr;
         end
         if (w_take) begin
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
         end
      end
   end

   // Software-written registers, byte lanes honoured
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_reg <= cfg_t'(`CFG_RST);
         timeout_reg <= `TIMEOUT_RST;
         dsx1_mask_reg <= `DSX1_MASK_RST;
         dsl_mask_reg <= `DSL_MASK_RST;
      end else begin
         if (wr_cfg) begin
            cfg_reg <= cfg_t'((cfg_reg & ~wmask[`CFG_W-1:0]) | wd_m[`CFG_W-1:0]);
         end
         if (wr_to) begin
            timeout_reg <= (timeout_reg & ~wmask[15:0]) | wd_m[15:0];
         end
         if (wr_dsx1) begin
            dsx1_mask_reg <= (dsx1_mask_reg & ~wmask[23:0]) | wd_m[23:0];
         end
         if (wr_dsl) begin
            dsl_mask_reg <= (dsl_mask_reg & ~wmask) | wd_m;
         end
      end
   end

   // Test state flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         net_user_reg <= 1'b0;
         net_remote_reg <= 1'b0;
         rep_reg <= 1'b0;
         dte_reg <= 1'b0;
         rem_reg <= 1'b0;
         rem_up_reg <= 1'b0;
         prbs_reg <= 1'b0;
         refused_reg <= 1'b0;
      end else begin
         net_user_reg <= net_user_next;
         net_remote_reg <= net_remote_next;
         rep_reg <= rep_next;
         dte_reg <= dte_next;
         rem_reg <= rem_next;
         rem_up_reg <= rem_ok ? cmd.remote_up_sel : rem_up_reg;
         prbs_reg <= prbs_next;
         // A new refusal wins over a write-one clear in the same cycle
         refused_reg <= refuse |
                        (refused_reg & ~(wr_stat & wd_m[`STATUS_REFUSED_BIT]));
      end
   end

   // Pattern checker: predicts each bit from the last nine received
   wire chk_pred = chk_reg[8] ^ chk_reg[4];
   wire synced = (sync_reg == `PRBS_SYNC_BITS);
   wire bit_err = prbs_reg & net_strobe & synced & (net_rx_bit != chk_pred);
   wire err_clr = cmd.error_count_clear | prbs_ok;

   // Generator, checker and error counter; an error in the clear cycle counts as one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gen_reg <= `PRBS_SEED;
         chk_reg <= 9'h000;
         sync_reg <= 4'h0;
         errcnt_reg <= 32'h00000000;
      end else begin
         if (net_strobe) begin
            gen_reg <= {gen_reg[7:0], gen_reg[8] ^ gen_reg[4]};
            chk_reg <= {chk_reg[7:0], net_rx_bit};
         end
         if (!prbs_reg) begin
            sync_reg <= 4'h0;
         end else if (net_strobe && !synced) begin
            sync_reg <= sync_reg + 4'h1;
         end
         if (err_clr) begin
            errcnt_reg <= bit_err ? 32'h00000001 : 32'h00000000;
         end else if (bit_err && errcnt_reg != 32'hFFFFFFFF) begin
            errcnt_reg <= errcnt_reg + 32'h00000001;
         end
      end
   end

   // Slot lookups; slots past the DSX-1 frame read as not connected
   wire [31:0] dsx1_mask_w = {8'h00, dsx1_mask_reg};
   wire dsx1_slot_hit = dsx1_mask_w[dte_slot];
   wire dsl_slot_hit = dsl_mask_reg[net_slot];
   wire dsx1 = cfg_reg.dsx1_variant;
   wire dsl_ds0 = (cfg_reg.dsl_mode == MODE_DS0);
   wire dsx1_ds0 = (cfg_reg.dsx1_mode == MODE_DS0);

   // Toward the tributary: a DTE-side loop outranks the pattern's fill
   wire dte_fill_net = dsx1 & (dsl_ds0 ? dsx1_slot_hit : 1'b1);
   wire dte_fill_prbs = dsx1 & dsx1_slot_hit;
   wire dte_tx_n = (rep_reg | dte_reg) ? dte_rx_bit :
                   net_act ? (dte_fill_net | core_dte_tx_bit) :
                   prbs_reg ? (dte_fill_prbs | core_dte_tx_bit) : core_dte_tx_bit;
   wire ais_n = net_act & dsx1 & ~dsl_ds0;

   // Toward the DSL line
   wire rep_cut = rep_reg & dsx1 & ~dsx1_ds0;
   wire dte_cut = dte_reg & dsx1 & ~dsx1_ds0;
   wire dte_slot_fill = dte_reg & dsx1 & dsx1_ds0 & dsl_slot_hit;
   wire net_tx_n = net_act ? net_rx_bit :
                   (rep_cut | dte_cut | dte_slot_fill) ? 1'b1 :
                   prbs_reg ? gen_reg[8] : core_net_tx_bit;
   // Received DSL data is discarded while a DTE-side loop runs with the DSX-1 variant set and the DSX-1 port not in DS0 mode
   wire core_net_rx_n = (rep_cut | dte_cut) ? 1'b1 : net_rx_bit;

   // Datapath and indicator flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         net_tx_reg <= 1'b1;
         dte_tx_reg <= 1'b1;
         core_net_rx_reg <= 1'b1;
         core_dte_rx_reg <= 1'b1;
         led_reg <= 1'b0;
         ais_reg <= 1'b0;
         eoc_reg <= 1'b1;
      end else begin
         net_tx_reg <= net_tx_n;
         dte_tx_reg <= dte_tx_n;
         core_net_rx_reg <= core_net_rx_n;
         core_dte_rx_reg <= dte_rx_bit;
         led_reg <= |act;
         ais_reg <= ais_n;
         eoc_reg <= ~rep_reg;
      end
   end

   // Read decoding
   wire ar_take = arvalid & arready_reg;
   wire rvalid_next = ar_take | (rvalid_reg & ~rready);
   wire [31:0] status_w = {24'h000000, refused_reg, rem_up_reg, net_remote_reg, act};
   wire [2:0] el_idx = 3'(araddr[4:2]);
   wire ra_ok = (araddr[1:0] == 2'h0) && ((araddr <= `REG_DSL_MASK) ||
                ((araddr >= `REG_ELAPSED0) && (araddr <= `REG_ELAPSED4)));
   wire [31:0] rd_w = (araddr == `REG_CFG) ? {25'h0000000, cfg_reg} :
                      (araddr == `REG_TIMEOUT) ? {16'h0000, timeout_reg} :
                      (araddr == `REG_STATUS) ? status_w :
                      (araddr == `REG_ERRCNT) ? errcnt_reg :
                      (araddr == `REG_DSX1_MASK) ? dsx1_mask_w :
                      (araddr == `REG_DSL_MASK) ? dsl_mask_reg :
                      (ra_ok && araddr >= `REG_ELAPSED0) ? {8'h00, hms[el_idx]} :
                      32'h00000000;

   // Read channel flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `RESP_OKAY;
      end else begin
         arready_reg <= ~rvalid_next;
         rvalid_reg <= rvalid_next;
         if (ar_take) begin
            rdata_reg <= rd_w;
            rresp_reg <= ra_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

   // Port drivers, all from flops
   assign awready = awready_reg;
   assign wready = wready_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = arready_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;
   assign net_tx_bit = net_tx_reg;
   assign dte_tx_bit = dte_tx_reg;
   assign core_net_rx_bit = core_net_rx_reg;
   assign core_dte_rx_bit = core_dte_rx_reg;
   assign remote_cmd_active = rem_reg;
   assign remote_cmd_up = rem_up_reg;
   assign test_led = led_reg;
   assign dte_ais = ais_reg;
   assign eoc_enable = eoc_reg;

   // Checks on the block's own behaviour
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_line_loop;
      net_act |=> net_tx_bit == $past(net_rx_bit);
   endproperty
   a_line_loop: assert property (p_line_loop) else $error("line loop altered data");

   property p_ais;
      net_act && dsx1 && !dsl_ds0 |=> dte_ais && dte_tx_bit;
   endproperty
   a_ais: assert property (p_ais) else $error("no AIS toward DSX-1");

   property p_line_refuse;
      cmd.line_start && (rep_reg || dte_reg || prbs_reg) && !net_user_reg |=> !net_user_reg;
   endproperty
   a_line_refuse: assert property (p_line_refuse) else $error("line loop not refused");

   property p_rep_loop;
      rep_reg |=> dte_tx_bit == $past(dte_rx_bit) && !eoc_enable;
   endproperty
   a_rep_loop: assert property (p_rep_loop) else $error("repeater loop path wrong");

   property p_rep_cut;
      rep_cut |=> net_tx_bit && core_net_rx_bit;
   endproperty
   a_rep_cut: assert property (p_rep_cut) else $error("repeater loop not filling ones");

   sequence s_rem_start;
      rem_ok ##1 (remote_cmd_active && remote_cmd_up == $past(cmd.remote_up_sel));
   endsequence
   property p_rem_start;
      rem_ok |-> s_rem_start;
   endproperty
   a_rem_start: assert property (p_rem_start) else $error("remote command not sent");

   property p_rem_len;
      remote_cmd_active |-> tot_sec[T_REM] <= 16'(`REMOTE_CMD_S);
   endproperty
   a_rem_len: assert property (p_rem_len) else $error("remote command overran");

   property p_rem_hold;
      remote_cmd_active && !rem_expire |=> remote_cmd_active;
   endproperty
   a_rem_hold: assert property (p_rem_hold) else $error("remote command stopped early");

   property p_err_clear;
      cmd.error_count_clear && !bit_err |=> errcnt_reg == 32'h00000000;
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("error count not cleared");

   property p_abort_spares;
      prbs_reg && cmd.abort_all && !cmd.prbs_stop && !timed_out[T_PRBS] |=> prbs_reg;
   endproperty
   a_abort_spares: assert property (p_abort_spares) else $error("abort ended pattern");

   property p_led;
      prbs_reg |=> test_led;
   endproperty
   a_led: assert property (p_led) else $error("test indicator dark in pattern");

endmodule : loop_test_ctrl

/* File: sim/remote_unit_model.sv */
// Far-end termination unit model: free-running 511 pattern source on the DSL receive side
`timescale 1ns/1ps
module remote_unit_model (
   // Clock, reset and error injection from the bench
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic err,
   // DSL receive stream toward the device
   output logic net_rx_bit,
   output logic net_strobe,
   output logic [4:0] net_slot,
   // Loop code detector pulses, idle here
   output logic remote_up_det,
   output logic remote_down_det
);
   logic [8:0] gen_reg; // Nine-stage generator, same seed as the device
   assign remote_up_det = 1'b0;
   assign remote_down_det = 1'b0;
   // Bits are valid every other cycle; between them the line shows junk, not the last bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gen_reg <= 9'h1FF;
         net_strobe <= 1'b0;
         net_rx_bit <= 1'b1;
         net_slot <= 5'h00;
      end else begin
         net_strobe <= ~net_strobe;
         if (!net_strobe) begin
            gen_reg <= {gen_reg[7:0], gen_reg[8] ^ gen_reg[4]};
            net_rx_bit <= gen_reg[8] ^ gen_reg[4] ^ err;
            net_slot <= net_slot + 5'h01;
         end else begin
            net_rx_bit <= ~net_rx_bit;
         end
      end
   end
endmodule : remote_unit_model

/* File: sim/test_loop_test_ctrl.sv */
// Register-level bench for the loop test control block
`timescale 1ns/1ps
`include "loop_test_defs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_loop_test_ctrl;
   // Bus, stream and tied inputs
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic dte_rx_bit = 0, err = 0, core_net_tx_bit = 0, core_dte_tx_bit = 0, r;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0] wstrb = 0;
   logic [4:0] dte_slot = 0, net_slot;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, net_rx_bit, net_strobe, net_tx_bit;
   logic dte_tx_bit, core_net_rx_bit, core_dte_rx_bit, remote_up_det, remote_down_det;
   logic remote_cmd_active, remote_cmd_up, test_led, dte_ais, eoc_enable;
   int mismatches = 0, n_tests = 0;
   always #12.5 aclk = ~aclk;
   always @(posedge aclk) dte_rx_bit <= ~dte_rx_bit;
   // Short second tick keeps the ten second command and timeouts cheap
   loop_test_ctrl #(.SEC_CYCLES(20)) u_dut (.*);
   remote_unit_model u_far (.*);
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc
   // Address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin @(posedge aclk); if (awready) awvalid <= 0; if (wready) wvalid <= 0; end
      while (bvalid !== 1'b1);
      bready <= 0;
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin @(posedge aclk); if (arready) arvalid <= 0; end while (rvalid !== 1'b1);
      rready <= 0;
      `CHK(rdata, e)
      `CHK(rresp, er)
   endtask : rc
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   initial begin
      cyc(3000);
      mismatches++;
      finish_test;
   end
   initial begin
      cyc(3); aresetn <= 1;
      rc(`REG_CFG, 32'h3, 2'h0);
      rc(`REG_TIMEOUT, 32'h258, 2'h0);
      rc(8'h1C, 32'h0, 2'h2);
      wr(`REG_CTRL, 32'h1); rc(`REG_STATUS, 32'h1, 2'h0);
      @(posedge aclk) r = net_rx_bit; #1 `CHK(net_tx_bit, r)
      `CHK(dte_ais, 1'b1)
      wr(`REG_CTRL, 32'h4); rc(`REG_STATUS, 32'h81, 2'h0);
      wr(`REG_CTRL, 32'h2); wr(`REG_STATUS, 32'h80);
      wr(`REG_CTRL, 32'h4); rc(`REG_STATUS, 32'h2, 2'h0);
      @(posedge aclk) r = dte_rx_bit; #1 `CHK(dte_tx_bit, r)
      `CHK(eoc_enable, 1'b0)
      `CHK(net_tx_bit, 1'b1)
      wr(`REG_CTRL, 32'h8);
      // Pattern test against the far-end source, one injected bit error
      wr(`REG_CTRL, 32'h100); cyc(40); rc(`REG_ERRCNT, 32'h0, 2'h0);
      `CHK(test_led, 1'b1)
      wr(`REG_CTRL, 32'h1); rc(`REG_STATUS, 32'h90, 2'h0);
      wr(`REG_STATUS, 32'h80);
      @(posedge aclk) err <= 1; cyc(2); err <= 0; cyc(40);
      rc(`REG_ERRCNT, 32'h3, 2'h0);
      wr(`REG_CTRL, 32'h800); rc(`REG_ERRCNT, 32'h0, 2'h0);
      wr(`REG_CTRL, 32'h400); rc(`REG_STATUS, 32'h10, 2'h0);
      wr(`REG_CTRL, 32'h200);
      // Remote up command, abort must not end it
      wr(`REG_CTRL, 32'hC0); rc(`REG_STATUS, 32'h48, 2'h0);
      wr(`REG_CTRL, 32'h400); rc(`REG_STATUS, 32'h48, 2'h0);
      `CHK(remote_cmd_up, 1'b1)
      cyc(220); `CHK(remote_cmd_active, 1'b0)
      rc(8'h2C, 32'hA, 2'h0);
      // The up/down choice of the last command stays readable after it ends
      wr(`REG_CFG, 32'h43); wr(`REG_CTRL, 32'h40); rc(`REG_STATUS, 32'hC0, 2'h0);
      wr(`REG_STATUS, 32'h80); wr(`REG_CFG, 32'h3);
      // DTE loop ended by a three second timeout
      wr(`REG_TIMEOUT, 32'h3); wr(`REG_CTRL, 32'h10);
      @(posedge aclk) r = dte_rx_bit; #1 `CHK(dte_tx_bit, r)
      cyc(100); rc(`REG_STATUS, 32'h40, 2'h0);
      rc(8'h28, 32'h3, 2'h0);
      finish_test;
   end
endmodule : test_loop_test_ctrl
